//--- setpoint_feed_compare.sv
/*
  Setpoint feed and compare block: material transfer feeder control and
  over/under zone sorting of the live weight, with an APB register file.
  Assumes gross and net weights and the discrete inputs are synchronous to
  pclk and that weights are signed two's complement in scale counts.
  The weight source is expected to present a fresh sample at least once per
  comparison tick; a slower source simply repeats its last value and the
  comparator acts on that repeated value.
  Discrete start/resume and pause/abort inputs are single-cycle pulses from
  an edge detector outside this block; a held level would act again on
  every cycle and could resume a transfer straight after an abort.
  Register writes take effect at the access edge of the APB transfer, and
  the feeder and zone pins are plain levels for external drivers.
*/
// Register access over APB and the placing of the registers were chosen for this implementation.
module setpoint_feed_compare
  import setpoint_pkg::*;
#(
  parameter int WEIGHT_W = 24,
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Weight stream.
  input wire logic signed [WEIGHT_W-1:0] gross_weight,
  input wire logic signed [WEIGHT_W-1:0] net_weight,
  // Discrete control inputs, one-cycle pulses.
  input wire logic start_resume_in,
  input wire logic pause_abort_in,
  // Discrete outputs.
  output feed_out_t feed_out
);

  // Eight bits of headroom keep target plus tolerance, and percentage
  // products of ordinary size, from wrapping in the comparisons.
  localparam int EXT_W = WEIGHT_W + 8;

  // Software-written configuration.
  logic [CTRL_WIDTH-1:0] ctrl;
  logic signed [WEIGHT_W-1:0] target, spill, fine, tol_pos, tol_neg, upper, lower;
  // Values frozen at start, so that edits during a latched run change
  // nothing until the next start.
  logic signed [WEIGHT_W-1:0] run_target, run_spill, run_fine;
  logic signed [WEIGHT_W-1:0] start_weight;
  // Comparison timing, transfer state and feeder decisions.
  logic [31:0] tick_cnt;
  logic tick;
  xfer_state_t state;
  zone_t zone;
  logic fast_on, slow_on;
  // Decoded commands and APB phase strobes.
  logic cmd_start, cmd_pause, cmd_abort;
  logic wr_en, setup_phase;

  wire tol_mode_t tol_mode = tol_mode_t'(ctrl[CTRL_TOL_LSB +: 2]);
  wire logic latched = ctrl[CTRL_LATCHED];

  // Access phase of an APB transfer; the slave always answers in one cycle.
  // Writes act on the access edge, where pready is high; the read word is
  // fetched one edge earlier, in the setup cycle, so that prdata can come
  // from a flip-flop and still be valid in the access cycle.
  assign wr_en = psel && penable && pwrite;
  assign setup_phase = psel && !penable;

  // Software and discrete commands merge; discrete ones are gated by enable.
  // The shared pause/abort input means pause while running and abort while
  // paused, so one pulse can never do both. A software command word with
  // several bits set is resolved by the state machine's priority.
  assign cmd_start = (wr_en && paddr == OFF_CMD && pwdata[CMD_START])
      || (ctrl[CTRL_DI_ENABLE] && start_resume_in);
  assign cmd_pause = (wr_en && paddr == OFF_CMD && pwdata[CMD_PAUSE])
      || (ctrl[CTRL_DI_ENABLE] && pause_abort_in && state == ST_RUNNING);
  assign cmd_abort = (wr_en && paddr == OFF_CMD && pwdata[CMD_ABORT])
      || (ctrl[CTRL_DI_ENABLE] && pause_abort_in && state == ST_PAUSED);

  // Configuration writes. Unmapped and read-only offsets change nothing;
  // the command offset is decoded above as pulses and stores no state.
  // Target values may be edited during a latched run without effect,
  // because the run works from its own snapshot. Coincidence mode, which
  // has no run, follows them at the next tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      target <= '0;
      spill <= '0;
      fine <= '0;
      tol_pos <= '0;
      tol_neg <= '0;
      upper <= '0;
      lower <= '0;
    end else if (wr_en) begin
      if (paddr == OFF_CTRL) begin
        ctrl <= pwdata[CTRL_WIDTH-1:0];
      end else if (paddr == OFF_TARGET) begin
        target <= pwdata[WEIGHT_W-1:0];
      end else if (paddr == OFF_SPILL) begin
        spill <= pwdata[WEIGHT_W-1:0];
      end else if (paddr == OFF_FINE) begin
        fine <= pwdata[WEIGHT_W-1:0];
      end else if (paddr == OFF_TOL_POS) begin
        tol_pos <= pwdata[WEIGHT_W-1:0];
      end else if (paddr == OFF_TOL_NEG) begin
        tol_neg <= pwdata[WEIGHT_W-1:0];
      end else if (paddr == OFF_UPPER) begin
        upper <= pwdata[WEIGHT_W-1:0];
      end else if (paddr == OFF_LOWER) begin
        lower <= pwdata[WEIGHT_W-1:0];
      end
    end
  end

  // Read mux and APB answer; unmapped addresses return an error.
  // Weights are returned sign-extended to the full bus width.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= PRDATA_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Outputs idle at zero outside the access cycle so that a stale word
      // is never mistaken for a fresh one.
      pready <= setup_phase;
      pslverr <= 1'b0;
      prdata <= PRDATA_RESET;
      if (setup_phase) begin
        if (paddr == OFF_CTRL) begin
          prdata <= 32'(ctrl);
        end else if (paddr == OFF_CMD) begin
          prdata <= PRDATA_RESET;
        end else if (paddr == OFF_TARGET) begin
          prdata <= 32'(target);
        end else if (paddr == OFF_SPILL) begin
          prdata <= 32'(spill);
        end else if (paddr == OFF_FINE) begin
          prdata <= 32'(fine);
        end else if (paddr == OFF_TOL_POS) begin
          prdata <= 32'(tol_pos);
        end else if (paddr == OFF_TOL_NEG) begin
          prdata <= 32'(tol_neg);
        end else if (paddr == OFF_UPPER) begin
          prdata <= 32'(upper);
        end else if (paddr == OFF_LOWER) begin
          prdata <= 32'(lower);
        end else if (paddr == OFF_STATUS) begin
          // Status packs state, both feeder flags and the zone into low bits.
          prdata <= 32'({zone, slow_on, fast_on, state});
        end else if (paddr == OFF_WEIGHT) begin
          // The readback uses the same gross or net choice as the comparator.
          prdata <= 32'(ctrl[CTRL_USE_NET] ? net_weight : gross_weight);
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Comparison tick divider. The tick is registered, so every decision made
  // on it lands one cycle after the count wraps and the feeder pins follow
  // one cycle later again. The divider runs freely, so the first decision
  // after a start comes within one tick period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_COUNT - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // Comparison arithmetic, widened so that sums and products of ordinary size cannot wrap.
  // All of it is combinational and is only acted upon at a tick, so one
  // settled value per tick is all that the downstream registers need.
  logic signed [EXT_W-1:0] weight, amount, fast_cut, slow_cut, ou_lo, ou_hi;
  logic signed [EXT_W-1:0] tgt_x, pct_pos, pct_neg;
  always_comb begin
    weight = EXT_W'(ctrl[CTRL_USE_NET] ? net_weight : gross_weight);
    // Dispensing measures what has left the scale since the start.
    amount = ctrl[CTRL_DISPENSE] ? EXT_W'(start_weight) - weight : weight;
    // Latched runs work from the start snapshot; coincidence has no start,
    // so it must follow the live settings or it would never see a new target.
    if (latched) begin
      slow_cut = EXT_W'(run_target) - EXT_W'(run_spill);
      fast_cut = slow_cut - EXT_W'(run_fine);
    end else begin
      slow_cut = EXT_W'(target) - EXT_W'(spill);
      fast_cut = slow_cut - EXT_W'(fine);
    end
    // The product is formed before the division so that small percentages
    // keep their precision; the result is rounded toward zero.
    tgt_x = EXT_W'(target);
    pct_pos = (tgt_x * EXT_W'(tol_pos)) / EXT_W'(PCT_DIVISOR);
    pct_neg = (tgt_x * EXT_W'(tol_neg)) / EXT_W'(PCT_DIVISOR);
    if (tol_mode == TOL_PERCENT) begin
      ou_lo = tgt_x - pct_neg;
      ou_hi = tgt_x + pct_pos;
    end else if (tol_mode == TOL_ABSOLUTE) begin
      ou_lo = EXT_W'(lower);
      ou_hi = EXT_W'(upper);
    end else begin
      ou_lo = tgt_x - EXT_W'(tol_neg);
      ou_hi = tgt_x + EXT_W'(tol_pos);
    end
  end

  // Transfer state: start, pause, resume, abort and completion.
  // Leaving latched mode or entering over/under mode drops any run at once,
  // so automated control exists only with latched outputs. A start that
  // arrives while running is ignored rather than retaking the snapshot.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // A reset drops any run; software must issue a fresh start.
      state <= ST_READY;
      run_target <= '0;
      run_spill <= '0;
      run_fine <= '0;
      start_weight <= '0;
    end else if (ctrl[CTRL_OVER_UNDER] || !latched) begin
      state <= ST_READY;
    end else begin
      case (state)
        ST_READY: begin
          if (cmd_start) begin
            state <= ST_RUNNING;
            // Snapshot so edits during a run do not disturb it.
            run_target <= target;
            run_spill <= spill;
            run_fine <= fine;
            start_weight <= ctrl[CTRL_USE_NET] ? net_weight : gross_weight;
          end
        end
        ST_RUNNING: begin
          // Pause wins over completion in one cycle; the resumed run then
          // completes at its next tick because the cutoff is already passed.
          if (cmd_pause) begin
            state <= ST_PAUSED;
          end else if (tick && amount >= slow_cut) begin
            state <= ST_READY;
          end
        end
        ST_PAUSED: begin
          // Abort takes priority over a resume issued in the same cycle.
          if (cmd_abort) begin
            state <= ST_READY;
          end else if (cmd_start) begin
            state <= ST_RUNNING;
          end
        end
        default: state <= ST_READY;
      endcase
    end
  end

  // Feeder decisions on each comparison tick.
  // The off conditions come first and act at once, not at the next tick:
  // a pause must cut power to the feeders without waiting up to a full
  // tick period, while turning a feeder on may wait for a fresh weight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_on <= 1'b0;
      slow_on <= 1'b0;
    end else if (ctrl[CTRL_OVER_UNDER]) begin
      fast_on <= 1'b0;
      slow_on <= 1'b0;
    end else if (latched && state != ST_RUNNING) begin
      fast_on <= 1'b0;
      slow_on <= 1'b0;
    end else if (latched && cmd_pause) begin
      fast_on <= 1'b0;
      slow_on <= 1'b0;
    end else if (tick) begin
      // Coincidence mode uses live settings and needs no start.
      if (!ctrl[CTRL_TWO_SPEED]) begin
        fast_on <= 1'b0;
        slow_on <= amount < slow_cut;
      end else if (ctrl[CTRL_INDEPENDENT]) begin
        // Independent feeders hand over at the fast cutoff, never overlapping.
        fast_on <= amount < fast_cut;
        slow_on <= amount >= fast_cut && amount < slow_cut;
      end else begin
        // Concurrent feeders start together; slow continues alone to the end.
        fast_on <= amount < fast_cut;
        slow_on <= amount < slow_cut;
      end
    end
  end

  // Over/under zone sorting; limits themselves count as ok.
  // Until the first tick after entering the mode no zone is shown, so an
  // external reject gate never acts on a result from before the switch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zone <= ZONE_NONE;
    end else if (!ctrl[CTRL_OVER_UNDER]) begin
      zone <= ZONE_NONE;
    end else if (tick) begin
      if (weight < ou_lo) begin
        zone <= ZONE_UNDER;
      end else if (weight > ou_hi) begin
        zone <= ZONE_OVER;
      end else begin
        zone <= ZONE_OK;
      end
    end
  end

  // Discrete outputs come from flip-flops.
  // Registering them costs a cycle of latency but keeps decode glitches off
  // the pins that drive actuators and indicator lamps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feed_out <= '0;
    end else begin
      feed_out.fast <= fast_on;
      feed_out.slow <= slow_on;
      feed_out.under <= zone == ZONE_UNDER;
      feed_out.ok <= zone == ZONE_OK;
      feed_out.over <= zone == ZONE_OVER;
    end
  end

  // Limitations a user must know:
  // - Coincidence compares against the live target, spill and fine values,
  //   so a write lands at the next tick. Dispensing in coincidence mode
  //   measures from the weight captured at the last latched start.
  // - Spill is not learned; software must tune it from observed overshoot.
  // - Percentage tolerances are rounded toward zero by the division.
  // - Very large targets times large percentages can exceed the widened
  //   arithmetic; keep target times tolerance within the headroom.
  // - Abort is refused unless paused; to stop a running transfer, pause
  //   it first and then abort.
  // - The tick period is fixed by a parameter; it does not follow the
  //   update rate of the weight source.

endmodule

//--- setpoint_pkg.sv
/*
  Package for the setpoint feed and compare block: register offsets, field
  positions, reset values, timing counts and shared types.
  Assumes a 100 MHz pclk and an APB slave with 32-bit data.
*/
package setpoint_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_TARGET = 8'h08;
  localparam logic [7:0] OFF_SPILL = 8'h0C;
  localparam logic [7:0] OFF_FINE = 8'h10;
  localparam logic [7:0] OFF_TOL_POS = 8'h14;
  localparam logic [7:0] OFF_TOL_NEG = 8'h18;
  localparam logic [7:0] OFF_UPPER = 8'h1C;
  localparam logic [7:0] OFF_LOWER = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_WEIGHT = 8'h28;

  // Control register field positions.
  localparam int CTRL_OVER_UNDER = 0;
  localparam int CTRL_USE_NET = 1;
  localparam int CTRL_LATCHED = 2;
  localparam int CTRL_TWO_SPEED = 3;
  localparam int CTRL_INDEPENDENT = 4;
  localparam int CTRL_DISPENSE = 5;
  localparam int CTRL_TOL_LSB = 6;
  localparam int CTRL_DI_ENABLE = 8;
  localparam int CTRL_WIDTH = 9;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h004;

  // Command register field positions; writes of one are pulses.
  localparam int CMD_START = 0;
  localparam int CMD_PAUSE = 1;
  localparam int CMD_ABORT = 2;

  // Status register field positions.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FAST = 2;
  localparam int STAT_SLOW = 3;
  localparam int STAT_ZONE_LSB = 4;

  // Comparison rate and derived tick period.
  localparam int CLK_HZ = 100_000_000;
  localparam int CMP_PER_SEC = 50;
  localparam int TICK_CYCLES = CLK_HZ / CMP_PER_SEC;
  localparam int PCT_DIVISOR = 100;

  localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {TOL_DEVIATION, TOL_PERCENT, TOL_ABSOLUTE} tol_mode_t;
  typedef enum logic [1:0] {ST_READY, ST_RUNNING, ST_PAUSED} xfer_state_t;
  typedef enum logic [1:0] {ZONE_NONE, ZONE_UNDER, ZONE_OK, ZONE_OVER} zone_t;

  // Feeder and zone outputs travel together.
  typedef struct packed {
    logic fast;
    logic slow;
    logic under;
    logic ok;
    logic over;
  } feed_out_t;

endpackage

//--- setpoint_monitor.sv
/*
  Port checker for the setpoint feed and compare block.
  Assumes it is bound to the block and sees only the block's ports.
*/
module setpoint_monitor
  import setpoint_pkg::*;
#(
  parameter int WEIGHT_W = 24,
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB and weights.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [WEIGHT_W-1:0] gross_weight,
  input wire logic signed [WEIGHT_W-1:0] net_weight,
  // Discrete outputs.
  input wire feed_out_t feed_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int gap;
  logic seen;
  // Cycles since the last feeder rise; rises may only land on the tick grid.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 0;
      seen <= 1'b0;
    end else if ($rose(feed_out.fast) || $rose(feed_out.slow)) begin
      gap <= 0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  error_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("bad error response");
  unmapped_error_a: assert property (pready && paddr > OFF_WEIGHT |-> pslverr)
    else $error("unmapped access not refused");
  command_reads_zero_a: assert property (pready && !pwrite && paddr == OFF_CMD |->
    prdata == 32'h0000_0000) else $error("command read not zero");
  weight_read_a: assert property (pready && !pwrite && paddr == OFF_WEIGHT |->
    prdata == 32'($past(gross_weight)) || prdata == 32'($past(net_weight)))
    else $error("weight read is neither gross nor net");
  zone_onehot_a: assert property ($onehot0({feed_out.under, feed_out.ok, feed_out.over}))
    else $error("more than one zone");
  mode_exclusive_a: assert property (!((feed_out.fast || feed_out.slow) &&
    (feed_out.under || feed_out.ok || feed_out.over))) else $error("zone and feed together");
  tick_grid_a: assert property (($rose(feed_out.fast) || $rose(feed_out.slow)) && seen
    |-> (gap + 1) % TICK_COUNT == 0) else $error("feed rise off the tick grid");
endmodule

//--- feeder_model.sv
/*
  Feeder and scale model: feed outputs move the weight, discrete pulses are made.
  Assumes the bench drives its control inputs on rising pclk edges.
*/
module feeder_model
  import setpoint_pkg::*;
#(
  parameter int TARE = 100
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls.
  input wire logic load_en,
  input wire logic signed [23:0] load_val,
  input wire logic removing,
  input wire logic push_start,
  input wire logic push_pause,
  // Block side.
  input wire feed_out_t feed_out,
  output logic signed [23:0] gross_weight,
  output logic signed [23:0] net_weight,
  output logic start_resume_in,
  output logic pause_abort_in
);
  logic signed [23:0] step;
  // Fast feed moves eight counts a cycle, slow one, so the fast cutoff is overshot.
  assign step = (feed_out.fast ? 24'sh8 : 24'sh0) + (feed_out.slow ? 24'sh1 : 24'sh0);
  assign net_weight = gross_weight - 24'(TARE);
  // The scale follows the feeders; removing runs them backwards.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gross_weight <= 24'sh0;
    end else if (load_en) begin
      gross_weight <= load_val;
    end else begin
      gross_weight <= removing ? gross_weight - step : gross_weight + step;
    end
  end
  // Discrete commands are single-cycle pulses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_resume_in <= 1'b0;
      pause_abort_in <= 1'b0;
    end else begin
      start_resume_in <= push_start;
      pause_abort_in <= push_pause;
    end
  end
endmodule

//--- setpoint_feed_compare_bench.sv
/*
  Self-checking bench for the setpoint feed and compare block.
  Assumes a 100 MHz pclk and a comparison tick shortened to TK cycles.
*/
module setpoint_feed_compare_bench
  import setpoint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  localparam int ZW [16] = '{479, 480, 510, 511, 399, 400, 550, 551,
    399, 400, 600, 601, 579, 580, 610, 611};
  localparam logic [31:0] ZC [4] = '{32'h0000_0001, 32'h0000_0041, 32'h0000_0081, 32'h0000_0003};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [23:0] gross, net, load_val;
  logic sr, pa, load_en, removing, push_start, push_pause;
  feed_out_t feed;
  int failures, checked;
  setpoint_feed_compare #(.TICK_COUNT(TK)) u_setpoint_feed_compare (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gross_weight(gross), .net_weight(net), .start_resume_in(sr), .pause_abort_in(pa),
    .feed_out(feed));
  feeder_model u_feeder_model (.pclk(pclk), .presetn(presetn), .load_en(load_en),
    .load_val(load_val), .removing(removing), .push_start(push_start),
    .push_pause(push_pause), .feed_out(feed), .gross_weight(gross), .net_weight(net),
    .start_resume_in(sr), .pause_abort_in(pa));
  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state limit here: only the watchdog may end a hung transfer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
    chk("pready", 32'h1, {31'h0, pready === 1'b0});
  endtask
  task automatic st(input xfer_state_t s);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("state", {30'h0, s}, {30'h0, rd[1:0]});
  endtask
  task automatic setw(input int w);
    {load_en, load_val} <= {1'b1, 24'(w)};
    @(posedge pclk);
    load_en <= 1'b0;
  endtask
  task automatic wait_fs(input logic [1:0] want);
    int n;
    n = 0;
    while ({feed.fast, feed.slow} !== want && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("feed", {30'h0, want}, {30'h0, feed.fast, feed.slow});
  endtask
  task automatic t_reset();
    chk("reset feed", 32'h0, 32'(feed));
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000_0004, rd);
    st(ST_READY);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test reset done");
  endtask
  // A latched run from start to cutoff, then the latch must hold the feeders off.
  task automatic t_run(input logic [31:0] c, input logic [1:0] f, input logic [1:0] m,
    input int base, input logic dir);
    apb(1'b1, OFF_CTRL, c);
    removing <= dir;
    setw(base);
    apb(1'b1, OFF_TARGET, 32'h0000_00C8);
    apb(1'b1, OFF_SPILL, 32'h0000_000A);
    apb(1'b1, OFF_FINE, 32'h0000_0032);
    repeat (3 * TK) @(posedge pclk);
    chk("idle", 32'h0, 32'(feed));
    apb(1'b1, OFF_CMD, 32'h0000_0001);
    st(ST_RUNNING);
    wait_fs(f);
    wait_fs(m);
    apb(1'b0, OFF_WEIGHT, 32'h0);
    chk("fast cut", 32'h1, 32'((dir ? base - $signed(rd) : $signed(rd) - base) >= 140
      || f == m));
    wait_fs(2'b00);
    apb(1'b0, OFF_WEIGHT, 32'h0);
    chk("slow cut", 32'h1, 32'((dir ? base - $signed(rd) : $signed(rd) - base) >= 190));
    st(ST_READY);
    setw(base);
    repeat (3 * TK) @(posedge pclk);
    chk("latched", 32'h0, 32'(feed));
    $display("test run done");
  endtask
  task automatic t_coin();
    apb(1'b1, OFF_CTRL, 32'h0);
    setw(0);
    wait_fs(2'b01);
    wait_fs(2'b00);
    setw(0);
    wait_fs(2'b01);
    setw(1000);
    wait_fs(2'b00);
    apb(1'b1, OFF_TARGET, 32'h0000_07D0);
    wait_fs(2'b01);
    apb(1'b1, OFF_CMD, 32'h0000_0001);
    st(ST_READY);
    $display("test coincidence done");
  endtask
  task automatic t_pause();
    apb(1'b1, OFF_CTRL, 32'h0000_0104);
    apb(1'b1, OFF_TARGET, 32'h0000_07D0);
    removing <= 1'b0;
    setw(0);
    push_start <= 1'b1;
    @(posedge pclk);
    push_start <= 1'b0;
    wait_fs(2'b01);
    apb(1'b1, OFF_CMD, 32'h0000_0004);
    st(ST_RUNNING);
    push_pause <= 1'b1;
    @(posedge pclk);
    push_pause <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("paused feed", 32'h0, 32'(feed));
    st(ST_PAUSED);
    apb(1'b1, OFF_TARGET, 32'h0000_0005);
    apb(1'b1, OFF_CMD, 32'h0000_0001);
    wait_fs(2'b01);
    apb(1'b1, OFF_CMD, 32'h0000_0002);
    st(ST_PAUSED);
    push_pause <= 1'b1;
    @(posedge pclk);
    push_pause <= 1'b0;
    repeat (6) @(posedge pclk);
    st(ST_READY);
    chk("aborted feed", 32'h0, 32'(feed));
    $display("test pause done");
  endtask
  // Zone edges: each group is under, lower edge, upper edge, over.
  task automatic t_zone();
    apb(1'b1, OFF_TARGET, 32'h0000_01F4);
    apb(1'b1, OFF_TOL_POS, 32'h0000_000A);
    apb(1'b1, OFF_TOL_NEG, 32'h0000_0014);
    apb(1'b1, OFF_UPPER, 32'h0000_0258);
    apb(1'b1, OFF_LOWER, 32'h0000_0190);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, OFF_CTRL, ZC[i / 4]);
      setw(ZW[i]);
      repeat (3 * TK) @(posedge pclk);
      chk("zone", (i % 4 == 0) ? 32'h4 : (i % 4 == 3) ? 32'h1 : 32'h2,
        {29'h0, feed.under, feed.ok, feed.over});
    end
    $display("test zones done");
  endtask
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog sized well above the expected run of a few thousand cycles.
  initial begin
    #300000;
    failures++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {load_en, load_val, removing, push_start, push_pause} = '0;
    failures = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_run(32'h0000_0004, 2'b01, 2'b01, 0, 1'b0);
    t_coin();
    t_run(32'h0000_000C, 2'b11, 2'b01, 0, 1'b0);
    t_run(32'h0000_001C, 2'b10, 2'b01, 0, 1'b0);
    t_run(32'h0000_0024, 2'b01, 2'b01, 1000, 1'b1);
    t_pause();
    t_zone();
    print_verdict();
  end
endmodule
bind setpoint_feed_compare setpoint_monitor #(.WEIGHT_W(WEIGHT_W), .TICK_COUNT(TICK_COUNT))
  u_setpoint_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gross_weight(gross_weight), .net_weight(net_weight), .feed_out(feed_out));
